// File: hw/system_clock_source_control.v
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "clk_ctrl_defs.vh"
module system_clock_source_control #(
	parameter MCD_TIMEOUT = `MCD_TIMEOUT_CYC,
	parameter XTAL_SETTLE = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire rst_pin_n_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire int_osc_clk_i,
	input wire int_osc_locked_i,
	input wire crystal_pin_in_i,
	input wire sysclk_edge_i,
	output wire sys_clk_o,
	output reg int_osc_run_o,
	output reg [1:0] int_freq_o,
	output reg ext_osc_run_o,
	output reg crystal_pin_in_ground_o,
	output reg [2:0] ext_freq_range_o,
	output reg ext_div2_o,
	output reg missing_clock_reset_o,
	output wire irq_o
);
	reg missing_clock_detect_enable;
	reg sysclk_source_select;
	reg internal_osc_enable;
	reg [1:0] internal_freq_select;
	reg [2:0] external_osc_mode;
	reg [2:0] external_freq_range;
	reg crystal_valid;
	reg internal_freq_ready;
	reg [2:0] irq_status;
	reg [2:0] irq_enable;
	reg [15:0] xtal_cnt;
	reg [31:0] mcd_cnt;
	reg [1:0] freq_seen;
	reg ready_q, valid_q;
	reg ext_clk_div;
	wire ext_active;
	wire acc;
	wire wr;
	wire [2:0] events;
	wire xtal_mode;
	wire ext_clk_raw;
	wire ext_clk;
	wire [7:0] internal_osc_control_reg;
	wire [7:0] external_osc_control_reg;

	assign acc = cyc_i & stb_i & ~ack_o;
	assign wr = acc & we_i & sel_i[0];
	assign xtal_mode = external_osc_mode[2] & external_osc_mode[1];

	// RQ10 bits read zero
	assign internal_osc_control_reg = {missing_clock_detect_enable, 2'b00, internal_freq_ready,
		sysclk_source_select, internal_osc_enable, internal_freq_select};
	// RQ14 reserved reads zero
	assign external_osc_control_reg = {crystal_valid, external_osc_mode, 1'b0, external_freq_range};

	// Register writes and reset values.
	always @(posedge clk_i) begin
		if (rst_i) begin
			// RQ1 boot from internal
			missing_clock_detect_enable <= 1'b0;
			sysclk_source_select <= 1'b0;
			internal_osc_enable <= 1'b1;
			internal_freq_select <= 2'b00;
			external_osc_mode <= 3'h3;
			external_freq_range <= 3'h0;
			irq_enable <= 3'h0;
		end else if (wr) begin
			if (adr_i == `ADDR_INT_CTRL) begin
				// RQ8 detector enable bit
				missing_clock_detect_enable <= dat_i[`BIT_MCD_EN];
				// RQ4 source select bit
				sysclk_source_select <= dat_i[`BIT_SRC_SEL];
				// RQ5 internal enable bit
				internal_osc_enable <= dat_i[`BIT_INT_EN];
				// RQ6 frequency field
				internal_freq_select <= dat_i[1:0];
			end
			if (adr_i == `ADDR_EXT_CTRL) begin
				// RQ11 mode field
				external_osc_mode <= dat_i[6:4];
				// RQ13 range field
				external_freq_range <= dat_i[2:0];
			end
			if (adr_i == `ADDR_IRQ_ENABLE)
				irq_enable <= dat_i[2:0];
		end
	end

	// Bus answer one cycle after the request; unmapped reads return zero.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= acc;
			if (acc & ~we_i) begin
				case (adr_i)
					`ADDR_INT_CTRL: dat_o <= {24'h0, internal_osc_control_reg};
					`ADDR_EXT_CTRL: dat_o <= {24'h0, external_osc_control_reg};
					`ADDR_IRQ_STATUS: dat_o <= {29'h0, irq_status};
					`ADDR_IRQ_ENABLE: dat_o <= {29'h0, irq_enable};
					default: dat_o <= 32'h0;
				endcase
			end
		end
	end

	// Oscillator drive outputs.
	always @(posedge clk_i) begin
		if (rst_i) begin
			int_osc_run_o <= 1'b0;
			ext_osc_run_o <= 1'b0;
			crystal_pin_in_ground_o <= 1'b1;
			int_freq_o <= 2'b00;
			ext_freq_range_o <= 3'h0;
			ext_div2_o <= 1'b0;
		end else begin
			// RQ3 reset pin stops both
			// RQ2 no start-up wait
			int_osc_run_o <= internal_osc_enable & rst_pin_n_i;
			// RQ15 runs while unselected
			ext_osc_run_o <= (external_osc_mode[2] | external_osc_mode[1]) & rst_pin_n_i;
			// RQ11 off grounds pin
			crystal_pin_in_ground_o <= ~(external_osc_mode[2] | external_osc_mode[1]);
			// Divide only in RC/C mode or odd CMOS and crystal codes; off mode never divides.
			ext_div2_o <= (external_osc_mode[2] & ~external_osc_mode[1]) | (external_osc_mode[1] & external_osc_mode[0]);
			int_freq_o <= internal_freq_select;
			ext_freq_range_o <= external_freq_range;
		end
	end

	// RQ12 crystal settle tracking
	always @(posedge clk_i) begin
		if (rst_i) begin
			xtal_cnt <= 16'h0;
			crystal_valid <= 1'b0;
		end else if (~xtal_mode | ~rst_pin_n_i) begin
			xtal_cnt <= 16'h0;
			crystal_valid <= 1'b0;
		end else if (xtal_cnt == XTAL_SETTLE[15:0]) begin
			crystal_valid <= 1'b1;
		end else begin
			xtal_cnt <= xtal_cnt + 16'h1;
		end
	end

	// RQ7 ready at chosen frequency
	always @(posedge clk_i) begin
		if (rst_i) begin
			freq_seen <= 2'b00;
			internal_freq_ready <= 1'b0;
		end else begin
			freq_seen <= internal_freq_select;
			internal_freq_ready <= int_osc_run_o & int_osc_locked_i & (freq_seen == internal_freq_select);
		end
	end

	// RQ9 one-shot timeout
	// Clk_i is a free reference, so the timeout counts even when the system clock stops.
	always @(posedge clk_i) begin
		if (rst_i) begin
			mcd_cnt <= 32'h0;
			missing_clock_reset_o <= 1'b0;
		end else if (~missing_clock_detect_enable | sysclk_edge_i) begin
			mcd_cnt <= 32'h0;
			missing_clock_reset_o <= 1'b0;
		end else if (mcd_cnt >= MCD_TIMEOUT - 1) begin
			missing_clock_reset_o <= 1'b1;
		end else begin
			mcd_cnt <= mcd_cnt + 32'h1;
		end
	end

	assign ext_clk_raw = crystal_pin_in_i & ~crystal_pin_in_ground_o;
	always @(posedge ext_clk_raw or posedge rst_i) begin
		if (rst_i)
			ext_clk_div <= 1'b0;
		else
			ext_clk_div <= ~ext_clk_div;
	end
	assign ext_clk = ext_div2_o ? ext_clk_div : ext_clk_raw;

	// RQ17 glitch-free switch
	clock_mux_glitchfree u_mux (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sel_ext_i(sysclk_source_select),
		.int_clk_i(int_osc_clk_i & int_osc_run_o),
		.ext_clk_i(ext_clk),
		.sys_clk_o(sys_clk_o),
		.ext_active_o(ext_active)
	);

	// Events: rising crystal valid, rising ready, detector firing. Set wins over clear.
	assign events = {missing_clock_reset_o, internal_freq_ready & ~ready_q, crystal_valid & ~valid_q};
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_q <= 1'b0;
			valid_q <= 1'b0;
			irq_status <= 3'h0;
		end else begin
			ready_q <= internal_freq_ready;
			valid_q <= crystal_valid;
			if (wr && adr_i == `ADDR_IRQ_CLEAR)
				irq_status <= (irq_status & ~dat_i[2:0]) | events;
			else
				irq_status <= irq_status | events;
		end
	end
	assign irq_o = |(irq_status & irq_enable);
endmodule // system_clock_source_control

// File: shared/clk_ctrl_defs.vh
// How it works
// RQ1: Reset always selects internal oscillator.
// RQ2: Internal oscillator ready immediately, no wait.
// RQ3: Reset pin low disables both oscillators.
// RQ4: Bit 3 selects internal or external clock.
// RQ5: Bit 2 enables internal oscillator.
// RQ6: Bits 1:0 choose 2/4/8/16 MHz.
// RQ7: Bit 4 reads ready at selected frequency.
// RQ8: Bit 7 enables missing clock detector reset.
// RQ9: Detector fires 100 to 500 us.
// RQ10: Bits 6:5 read zero, writes ignored.
// RQ11: Mode field selects off/CMOS/RC/crystal, divide.
// RQ12: Crystal valid flag at bit 7.
// RQ13: Bits 2:0 set external drive range.
// RQ14: Bit 3 reserved, writes ignored.
// RQ15: External oscillator runs while unselected.
// RQ16: Software waits 1 ms, polls valid.
// RQ17: Source switching is glitch free.
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH
`define ADDR_EXT_CTRL 8'hb1
`define ADDR_INT_CTRL 8'hb2
`define ADDR_IRQ_STATUS 8'hb4
`define ADDR_IRQ_ENABLE 8'hb8
`define ADDR_IRQ_CLEAR 8'hbc
`define EXT_CTRL_RESET 8'h30
`define INT_CTRL_RESET 8'h04
`define BIT_MCD_EN 7
`define BIT_FREQ_READY 4
`define BIT_SRC_SEL 3
`define BIT_INT_EN 2
`define BIT_XTAL_VALID 7
`define MCD_TIMEOUT_US 220
`define CLK_MHZ 10
`define MCD_TIMEOUT_CYC (`MCD_TIMEOUT_US * `CLK_MHZ)
`define IRQ_XTAL_VALID 0
`define IRQ_FREQ_READY 1
`define IRQ_MCD 2
`endif

// File: hw/clock_mux_glitchfree.v
`timescale 1ns/1ps
module clock_mux_glitchfree (
	input wire clk_i,
	input wire rst_i,
	input wire sel_ext_i,
	input wire int_clk_i,
	input wire ext_clk_i,
	output wire sys_clk_o,
	output reg ext_active_o
);
	reg int_on;
	reg ext_on;
	reg int_s1, int_s2, ext_s1, ext_s2;
	// RQ17 break before make
	always @(posedge clk_i) begin
		if (rst_i) begin
			int_s1 <= 1'b1;
			int_s2 <= 1'b1;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
		end else begin
			int_s1 <= ~sel_ext_i & ~ext_s2;
			int_s2 <= int_s1;
			ext_s1 <= sel_ext_i & ~int_s2;
			ext_s2 <= ext_s1;
		end
	end
	// Gate enables change only while the gated clock is low.
	always @(negedge int_clk_i or posedge rst_i) begin
		if (rst_i)
			int_on <= 1'b1;
		else
			int_on <= int_s2;
	end
	always @(negedge ext_clk_i or posedge rst_i) begin
		if (rst_i)
			ext_on <= 1'b0;
		else
			ext_on <= ext_s2;
	end
	assign sys_clk_o = (int_clk_i & int_on) | (ext_clk_i & ext_on);
	always @(posedge clk_i) begin
		if (rst_i)
			ext_active_o <= 1'b0;
		else
			ext_active_o <= ext_s2;
	end
endmodule // clock_mux_glitchfree

// File: testbench/osc_partner.sv
`timescale 1ns/1ps
module osc_partner (
	input wire logic clk_i,
	input wire logic stop_i,
	output logic osc_o,
	output logic xtal_o,
	output logic edge_o
);
	initial osc_o = 1'b0;
	initial xtal_o = 1'b0;
	initial edge_o = 1'b0;
	always #31 osc_o = !osc_o;
	// crystal runs freely
	// Its period is unrelated to clk_i, as a real crystal would be.
	always #73 xtal_o = !xtal_o;
	always @(posedge clk_i) edge_o <= !stop_i;
endmodule // osc_partner

// File: testbench/scsc_props.sv
`timescale 1ns/1ps
module scsc_props #(parameter MCD_TIMEOUT = 20) (
	input wire clk_i,
	input wire rst_i,
	input wire rst_pin_n_i,
	input wire cyc_i,
	input wire stb_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire sysclk_edge_i,
	input wire int_osc_run_o,
	input wire ext_osc_run_o,
	input wire crystal_pin_in_ground_o,
	input wire missing_clock_reset_o,
	input wire irq_o
);
	int gap;
	always @(posedge clk_i) gap <= (rst_i || sysclk_edge_i) ? 0 : gap + 1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	a_read_width: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data");
	a_pin_int_off: assert property (!rst_pin_n_i [*2] |-> !int_osc_run_o) else $error("int run");
	a_pin_ext_off: assert property (!rst_pin_n_i [*2] |-> !ext_osc_run_o) else $error("ext run");
	a_edge_rearm: assert property (sysclk_edge_i [*2] |=> !missing_clock_reset_o) else $error("mcd");
	// Rise only: the output may lag the restart of edges by a cycle or two.
	a_mcd_early: assert property ($rose(missing_clock_reset_o) |-> gap >= MCD_TIMEOUT - 2) else $error("early");
	a_ground_off: assert property (crystal_pin_in_ground_o |-> !ext_osc_run_o) else $error("ground");
	cover property ($rose(missing_clock_reset_o));
	cover property ($rose(irq_o));
	cover property (crystal_pin_in_ground_o ##1 !crystal_pin_in_ground_o);
endmodule // scsc_props
bind system_clock_source_control scsc_props #(.MCD_TIMEOUT(MCD_TIMEOUT)) i_scsc_props (.clk_i(clk_i),
	.rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
	.sysclk_edge_i(sysclk_edge_i), .int_osc_run_o(int_osc_run_o), .ext_osc_run_o(ext_osc_run_o),
	.crystal_pin_in_ground_o(crystal_pin_in_ground_o), .missing_clock_reset_o(missing_clock_reset_o), .irq_o(irq_o));

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] DIV2 = 8'hb8;
	logic clk_i = 0, rst_i = 1, rst_pin_n_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, lock = 0, stop = 0;
	logic [7:0] adr_i = 8'h00;
	logic [7:0] q;
	logic [31:0] dat_i = 32'h0;
	wire [31:0] dat_o;
	wire ack_o, osc, xtal, sedge, irq_o, int_run, ext_run, gnd, div2, mcd;
	wire [1:0] ifreq;
	wire [2:0] xrange;
	int n_mismatch = 0, checks = 0;
	always #50 clk_i = !clk_i;
	osc_partner i_osc_partner (.clk_i(clk_i), .stop_i(stop), .osc_o(osc), .xtal_o(xtal), .edge_o(sedge));
	system_clock_source_control #(.MCD_TIMEOUT(20), .XTAL_SETTLE(16)) i_system_clock_source_control (
		.clk_i(clk_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .int_osc_clk_i(osc),
		.int_osc_locked_i(lock), .crystal_pin_in_i(xtal), .sysclk_edge_i(sedge), .sys_clk_o(),
		.int_osc_run_o(int_run), .int_freq_o(ifreq), .ext_osc_run_o(ext_run), .crystal_pin_in_ground_o(gnd),
		.ext_freq_range_o(xrange), .ext_div2_o(div2), .missing_clock_reset_o(mcd), .irq_o(irq_o));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task print_verdict;
		if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#600000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'hb2, 8'h04);
		rd(8'hb1, 8'h30);
		rd(8'hc0, 8'h00);
		chk(8'(int_run), 8'h01);
		lock <= 1'b1;
		@(posedge clk_i);
		rd(8'hb2, 8'h14);
		wb(1'b1, 8'hb2, 8'h6f);
		rd(8'hb2, 8'h1f);
		chk(8'(ifreq), 8'h03);
		for (int m = 0; m < 8; m++) begin
			wb(1'b1, 8'hb1, 8'(m << 4));
			chk(8'({gnd, div2}), 8'({m < 2, DIV2[m]}));
		end
		wb(1'b1, 8'hb1, 8'h6f);
		chk(8'(xrange), 8'h07);
		repeat (40) @(posedge clk_i);
		rd(8'hb1, 8'he7);
		rd(8'hb4, 8'h03);
		chk(8'(irq_o), 8'h00);
		wb(1'b1, 8'hb8, 8'h01);
		chk(8'(irq_o), 8'h01);
		wb(1'b1, 8'hbc, 8'h01);
		chk(8'(irq_o), 8'h00);
		wb(1'b1, 8'hb2, 8'h8f);
		stop <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk(8'(mcd), 8'h01);
		stop <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(8'(mcd), 8'h00);
		rst_pin_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(8'({int_run, ext_run}), 8'h00);
		rst_pin_n_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(8'hb2, 8'h14);
		print_verdict;
	end
endmodule // testbench
